// *** dv/return_stack_pointer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "return_stack_defines.svh"
module return_stack_pointer_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        core_reset = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        resp_valid, resp_underflow, overflow_reset_req, irq, pready, pslverr, err;
  logic [20:0] resp_pc;
  logic [31:0] prdata, rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  return_stack_pkg::stack_req_type req;

  return_stack_sequencer seq (.sys_clk(sys_clk), .req(req));
  return_stack_pointer dut (.sys_clk(sys_clk), .rst_n(rst_n), .core_reset(core_reset),
    .req(req), .resp_valid(resp_valid), .resp_underflow(resp_underflow), .resp_pc(resp_pc),
    .overflow_reset_req(overflow_reset_req), .irq(irq), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .pslverr(pslverr), .prdata(prdata));

  initial forever #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  function automatic logic [31:0] pv(input logic [4:0] p, input logic u, input logic f);
    return {24'h0, f, u, 1'b0, p};
  endfunction : pv

  task automatic pulse_core;
    @(posedge sys_clk);
    core_reset <= 1'b1;
    @(posedge sys_clk);
    core_reset <= 1'b0;
  endtask : pulse_core

  task automatic t_reset;
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b0, 1'b0));
    rdchk(`RSP_OFF_CONFIG, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_push_pop;
    for (int i = 1; i <= 3; i++) seq.op(1'b1, 21'h100 + 21'(i));
    rdchk(`RSP_OFF_POINTER, pv(5'h03, 1'b0, 1'b0));
    rdchk(`RSP_OFF_TOP, 32'h103);
    seq.push_pop(21'h1aa);
    #1 chk({9'h0, resp_valid, resp_underflow, resp_pc}, {9'h0, 1'b1, 1'b0, 21'h1aa});
    for (int i = 3; i >= 0; i--) begin
      seq.op(1'b0, 21'h0);
      #1 chk({9'h0, resp_valid, resp_underflow, resp_pc},
             {9'h0, 1'b1, i == 0, (i == 0) ? 21'h0 : 21'h100 + 21'(i)});
    end
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b1, 1'b0));
    rdchk(`RSP_OFF_IRQ_STATUS, 32'h2);
    rdchk(`RSP_OFF_TOP, 32'h0);
    seq.op(1'b1, 21'h0aa);
    rdchk(`RSP_OFF_POINTER, pv(5'h01, 1'b1, 1'b0));
    apb(1'b1, `RSP_OFF_POINTER, 32'h4);
    rdchk(`RSP_OFF_POINTER, pv(5'h04, 1'b0, 1'b0));
    pulse_core();
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b0, 1'b0));
    $display("test push pop done");
  endtask : t_push_pop

  task automatic t_overflow(input logic en);
    apb(1'b1, `RSP_OFF_CONFIG, {31'h0, en});
    apb(1'b1, `RSP_OFF_IRQ_MASK, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    for (int i = 1; i <= 31; i++) seq.op(1'b1, 21'h200 + 21'(i));
    #1 chk({31'h0, overflow_reset_req}, {31'h0, en});
    rdchk(`RSP_OFF_POINTER, pv(en ? 5'h00 : 5'h1f, 1'b0, 1'b1));
    chk({31'h0, irq}, 32'h1);
    if (en) apb(1'b1, `RSP_OFF_POINTER, 32'h9f);
    if (!en) seq.op(1'b1, 21'h3ff);
    rdchk(`RSP_OFF_TOP, en ? 32'h221 : 32'h21f);
    rdchk(`RSP_OFF_POINTER, pv(5'h1f, 1'b0, 1'b1));
    pulse_core();
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b0, 1'b1));
    apb(1'b1, `RSP_OFF_IRQ_STATUS, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rdchk(`RSP_OFF_IRQ_STATUS, 32'h2);
    rdchk(`RSP_OFF_IRQ_MASK, 32'h1);
    apb(1'b1, `RSP_OFF_POINTER, 32'h0);
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b0, 1'b0));
    $display("test overflow done");
  endtask : t_overflow

  task automatic t_power_on;
    seq.op(1'b0, 21'h0);
    apb(1'b1, `RSP_OFF_IRQ_MASK, 32'h3);
    #1 chk({31'h0, irq}, 32'h1);
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b1, 1'b0));
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(`RSP_OFF_POINTER, pv(5'h00, 1'b0, 1'b0));
    rdchk(`RSP_OFF_CONFIG, 32'h1);
    rdchk(`RSP_OFF_IRQ_STATUS, 32'h0);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test power on done");
  endtask : t_power_on

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_push_pop();
    t_overflow(1'b1);
    t_overflow(1'b0);
    t_power_on();
    final_report();
  end
endmodule : return_stack_pointer_tb_top
`default_nettype wire

// *** dv/return_stack_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module return_stack_sequencer (
  input  wire logic                            sys_clk,
  output var  return_stack_pkg::stack_req_type req
);
  initial req = '0;
  // One push or one pop per call; pc line is scrambled when idle
  task automatic op(input logic push, input logic [20:0] pc);
    @(posedge sys_clk);
    req <= '{push, !push, pc};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~pc};
  endtask : op
  // Push, then pop on the very next cycle
  task automatic push_pop(input logic [20:0] pc);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, pc};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, ~pc};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~pc};
  endtask : push_pop
endmodule : return_stack_sequencer
`default_nettype wire

// *** logic/return_stack_pointer.sv ***
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "return_stack_defines.svh"

// Behaviour
// R1 - Pointer 0..31, push adds one, pop subtracts
// R2 - Every reset clears the pointer to zero
// R3 - Software reads and overwrites the pointer
// R4 - Full flag sets on thirty-first push
// R5 - Full flag sticky until software or power-on
// R6 - Overflow reset: store pc+2, flag, reset
// R7 - Overflow reset enable defaults to enabled
// R8 - Without overflow reset, pointer advances to 31
// R9 - At 31, further pushes change nothing; code still sets full flags, resets pointer if overflow reset on
// R10 - Empty pop returns zero, sets underflow flag
// R11 - Underflow flag sticky until software or power-on
// R12 - Push increments then writes; pop reads then decrements
// R13 - Thirty-one entries of 21 bits, zero unmapped
// R14 - No simultaneous push and pop; writes apply next cycle
module return_stack_pointer #(
  parameter int PTR_W = 5,
  parameter int PC_W  = 21,
  parameter int DEPTH = 31
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  input  wire logic                           core_reset,
  input  wire return_stack_pkg::stack_req_type req,
  output logic                                resp_valid,
  output logic                                resp_underflow,
  output logic [PC_W-1:0]                     resp_pc,
  output logic                                overflow_reset_req,
  output logic                                irq,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic                                pready,
  output logic                                pslverr,
  output logic [31:0]                         prdata
);

  if (PTR_W != return_stack_pkg::PTR_W || PC_W != return_stack_pkg::PC_W ||
      DEPTH != (1 << PTR_W) - 1) begin : g_param_check
    $error("return_stack_pointer: widths must match the package and DEPTH 2**PTR_W-1");
  end

  // State
  logic [PTR_W-1:0] return_stack_pointer_reg;
  logic             stack_full_flag;
  logic             stack_underflow_flag;
  logic             overflow_reset_enable;
  logic [1:0]       irq_status;
  logic [1:0]       irq_mask;
  logic [PC_W-1:0]  stack_mem [1:DEPTH];

  // Sequencer requests, gated off while the core is held in reset
  wire push_ok = req.push & ~core_reset; // R14
  wire pop_ok  = req.pop & ~req.push & ~core_reset; // R14

  wire [PTR_W-1:0] ptr_plus  = PTR_W'(return_stack_pointer_reg + 1'b1);
  wire [PTR_W-1:0] ptr_minus = PTR_W'(return_stack_pointer_reg - 1'b1);
  wire             ptr_zero  = return_stack_pointer_reg == `RSP_PTR_RESET;
  wire             ptr_top   = return_stack_pointer_reg == `RSP_PTR_MAX;
  wire             ptr_fills = ptr_plus == `RSP_PTR_MAX;

  // Overflow events
  wire set_full       = push_ok & (ptr_fills | ptr_top); // R4
  wire ovf_reset_fire = push_ok & overflow_reset_enable & (ptr_fills | ptr_top); // R6
  wire set_underflow  = pop_ok & ptr_zero; // R10

  // Storage write: increment first, then write the selected entry
  wire             mem_write = push_ok & ~ptr_top; // R9 R12
  wire [PC_W-1:0]  pc_plus   = PC_W'(req.pc + `RSP_PC_STEP);
  wire [PC_W-1:0]  mem_wdata = (ptr_fills & overflow_reset_enable) ? pc_plus : req.pc; // R6

  // Entry zero has no storage
  wire [PTR_W-1:0] rd_idx   = ptr_zero ? PTR_W'(1) : return_stack_pointer_reg; // R13
  wire [PC_W-1:0]  top_data = ptr_zero ? `RSP_UNDERFLOW_PC : stack_mem[rd_idx]; // R13

  // APB decode
  wire sel_ptr    = paddr == `RSP_OFF_POINTER;
  wire sel_cfg    = paddr == `RSP_OFF_CONFIG;
  wire sel_status = paddr == `RSP_OFF_IRQ_STATUS;
  wire sel_mask   = paddr == `RSP_OFF_IRQ_MASK;
  wire sel_top    = paddr == `RSP_OFF_TOP;
  wire addr_hit   = sel_ptr | sel_cfg | sel_status | sel_mask | sel_top;
  wire access     = psel & penable;
  wire wr_en      = access & pwrite & addr_hit;
  wire wr_lane0   = wr_en & pstrb[0];
  wire ptr_wr     = wr_lane0 & sel_ptr;
  wire cfg_wr     = wr_lane0 & sel_cfg;
  wire status_wr  = wr_lane0 & sel_status;
  wire mask_wr    = wr_lane0 & sel_mask;

  assign pready  = 1'b1;
  assign pslverr = access & ~addr_hit;

  wire [31:0] ptr_word = {24'h000000, stack_full_flag, stack_underflow_flag, 1'b0,
                          return_stack_pointer_reg};
  wire [31:0] rd_mux =
    sel_ptr    ? ptr_word :
    sel_cfg    ? {31'h0, overflow_reset_enable} :
    sel_status ? {30'h0, irq_status} :
    sel_mask   ? {30'h0, irq_mask} :
    sel_top    ? {11'h0, top_data} : 32'h00000000;

  // Next pointer: any reset first, then software, then the sequencer
  logic [PTR_W-1:0] next_ptr;
  always_comb begin
    if (core_reset || ovf_reset_fire) begin
      next_ptr = `RSP_PTR_RESET; // R2 R6
    end else if (ptr_wr) begin
      next_ptr = pwdata[`RSP_PTR_MSB:`RSP_PTR_LSB]; // R3
    end else if (push_ok) begin
      next_ptr = ptr_top ? return_stack_pointer_reg : ptr_plus; // R1 R8 R9
    end else if (pop_ok) begin
      next_ptr = ptr_zero ? `RSP_PTR_RESET : ptr_minus; // R1 R10
    end else begin
      next_ptr = return_stack_pointer_reg;
    end
  end

  // Flags: hardware set wins over a software clear
  wire next_full = set_full |
                   (ptr_wr ? pwdata[`RSP_FULL_BIT] : stack_full_flag); // R5
  wire next_unf  = set_underflow |
                   (ptr_wr ? pwdata[`RSP_UNDERFLOW_BIT] : stack_underflow_flag); // R11

  wire [1:0] irq_set      = {set_underflow, set_full};
  wire [1:0] irq_clr      = status_wr ? pwdata[1:0] : 2'h0;
  wire [1:0] next_status  = irq_set | (irq_status & ~irq_clr);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      return_stack_pointer_reg <= `RSP_PTR_RESET; // R2
      stack_full_flag          <= 1'b0;
      stack_underflow_flag     <= 1'b0;
    end else begin
      return_stack_pointer_reg <= next_ptr;
      stack_full_flag          <= next_full;
      stack_underflow_flag     <= next_unf;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_reset_enable <= `RSP_CFG_OVF_RESET; // R7
      irq_status            <= `RSP_IRQ_RESET;
      irq_mask              <= `RSP_IRQ_RESET;
    end else begin
      overflow_reset_enable <= cfg_wr ? pwdata[`RSP_CFG_OVF_BIT] : overflow_reset_enable;
      irq_status            <= next_status;
      irq_mask              <= mask_wr ? pwdata[1:0] : irq_mask;
    end
  end

  // Storage holds no reset; entry zero does not exist
  always_ff @(posedge sys_clk) begin
    if (mem_write) begin
      stack_mem[ptr_plus] <= mem_wdata; // R12 R13
    end
  end

  // Pop answer: read selected entry, pointer drops next edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid         <= 1'b0;
      resp_underflow     <= 1'b0;
      resp_pc            <= `RSP_UNDERFLOW_PC;
      overflow_reset_req <= 1'b0;
      prdata             <= 32'h00000000;
    end else begin
      resp_valid         <= pop_ok;
      resp_underflow     <= set_underflow;
      resp_pc            <= pop_ok ? top_data : resp_pc; // R10 R12
      overflow_reset_req <= ovf_reset_fire; // R6
      prdata             <= (psel && !penable && !pwrite) ? rd_mux : prdata;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic started;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  a_push_increments: assert property ( // R1
    push_ok && !ptr_wr && !ptr_top && !ptr_fills
    |=> return_stack_pointer_reg == $past(return_stack_pointer_reg) + 5'h01)
    else $error("push did not advance the pointer by one");

  a_pop_decrements: assert property ( // R1
    pop_ok && !ptr_wr && !ptr_zero
    |=> return_stack_pointer_reg == $past(return_stack_pointer_reg) - 5'h01)
    else $error("pop did not lower the pointer by one");

  a_core_reset_zero: assert property ( // R2
    core_reset |=> return_stack_pointer_reg == 5'h00 && !resp_valid)
    else $error("core reset left the pointer nonzero");

  a_sw_ptr_write: assert property ( // R3
    ptr_wr && !core_reset && !ovf_reset_fire
    |=> return_stack_pointer_reg == $past(pwdata[4:0]))
    else $error("software pointer write not applied");

  a_full_on_fill: assert property ( // R4
    push_ok && return_stack_pointer_reg == 5'h1e |=> stack_full_flag && irq_status[0])
    else $error("full flag missing after thirty-first push");

  a_full_sticky: assert property ( // R5
    stack_full_flag && !ptr_wr |=> stack_full_flag)
    else $error("full flag dropped without software write");

  a_ovf_reset_seq: assert property ( // R6
    push_ok && overflow_reset_enable && return_stack_pointer_reg == 5'h1e
    |=> overflow_reset_req && return_stack_pointer_reg == 5'h00 && stack_full_flag
        ##1 !overflow_reset_req)
    else $error("overflow reset sequence wrong");

  a_ovf_stores_pc2: assert property ( // R6
    push_ok && overflow_reset_enable && ptr_fills
    |=> stack_mem[31] == $past(req.pc) + 21'h000002)
    else $error("overflow push did not store pc plus two");

  a_cfg_default: assert property ( // R7
    !started |-> overflow_reset_enable && !overflow_reset_req)
    else $error("overflow reset enable not set after reset");

  a_no_reset_fill: assert property ( // R8
    push_ok && !overflow_reset_enable && ptr_fills && !ptr_wr
    |=> return_stack_pointer_reg == 5'h1f && !overflow_reset_req
        && stack_mem[31] == $past(req.pc))
    else $error("disabled overflow reset did not fill to 31");

  a_top_saturates: assert property ( // R9
    push_ok && !overflow_reset_enable && ptr_top && !ptr_wr
    |=> return_stack_pointer_reg == 5'h1f && $stable(stack_mem[31]))
    else $error("push at top changed the stack");

  a_empty_pop: assert property ( // R10
    pop_ok && ptr_zero && !ptr_wr
    |=> resp_valid && resp_underflow && resp_pc == 21'h000000
        && return_stack_pointer_reg == 5'h00 && stack_underflow_flag)
    else $error("empty pop answer wrong");

  a_unf_sticky: assert property ( // R11
    stack_underflow_flag && !ptr_wr |=> stack_underflow_flag)
    else $error("underflow flag dropped without software write");

  a_push_then_pop: assert property ( // R12
    push_ok && !ptr_top && !ptr_fills && !ptr_wr ##1 pop_ok && !ptr_wr
    |=> resp_valid && resp_pc == $past(req.pc, 2) && !resp_underflow)
    else $error("pop did not return the value just pushed");

  a_zero_unmapped: assert property ( // R13
    ptr_zero && psel && !penable && !pwrite && sel_top |=> prdata == 32'h00000000)
    else $error("pointer zero selected a storage entry");

  a_irq_level: assert property ( // R4
    push_ok && ptr_fills && irq_mask[0] && !mask_wr |=> irq)
    else $error("unmasked full event did not raise the interrupt");

  // Sticky flags, core reset, overflow request and pop answer
  a_core_keeps_flags: assert property ( // R5
    core_reset && !ptr_wr
    |=> stack_full_flag == $past(stack_full_flag)
        && stack_underflow_flag == $past(stack_underflow_flag))
    else $error("core reset changed a sticky flag");

  a_full_set_wins: assert property ( // R4
    push_ok && (ptr_fills || ptr_top)
    |=> stack_full_flag && irq_status[0])
    else $error("full event lost to a software clear");

  a_unf_set_wins: assert property ( // R10
    pop_ok && ptr_zero
    |=> stack_underflow_flag && irq_status[1])
    else $error("underflow event lost to a software clear");

  a_ovf_pulse_once: assert property ( // R6
    overflow_reset_req |=> !overflow_reset_req)
    else $error("overflow reset request longer than one cycle");

  a_disabled_no_reset: assert property ( // R8
    push_ok && !overflow_reset_enable
    |=> !overflow_reset_req)
    else $error("overflow reset fired while disabled");

  a_resp_one_cycle: assert property ( // R12
    !pop_ok
    |=> !resp_valid && !resp_underflow)
    else $error("pop answer without a pop");

  a_resp_pc_holds: assert property ( // R12
    !pop_ok
    |=> $stable(resp_pc))
    else $error("popped value changed without a pop");

  // Register bus checks
  a_ready_no_wait: assert property (
    psel && penable |-> pready)
    else $error("access phase not answered at once");

  a_pslverr_unmapped: assert property (
    psel && penable && !addr_hit |-> pslverr)
    else $error("unmapped access not flagged");

  a_unmapped_reads_zero: assert property (
    psel && !penable && !pwrite && !addr_hit
    |=> prdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  a_cfg_write: assert property (
    cfg_wr
    |=> overflow_reset_enable == $past(pwdata[0]))
    else $error("configuration write not applied");

  a_mask_write: assert property (
    mask_wr
    |=> irq_mask == $past(pwdata[1:0]))
    else $error("mask write not applied");

  a_status_w1c: assert property (
    status_wr && pwdata[0] && !set_full
    |=> !irq_status[0])
    else $error("full status bit not cleared by a one");

  a_status_sticky: assert property ( // R11
    irq_status[1] && !(status_wr && pwdata[1])
    |=> irq_status[1])
    else $error("underflow status bit dropped without a clear");

endmodule : return_stack_pointer

`default_nettype wire

// *** shared/return_stack_defines.svh ***
`ifndef RETURN_STACK_DEFINES_SVH
`define RETURN_STACK_DEFINES_SVH

// Register byte offsets
`define RSP_OFF_POINTER     12'h000
`define RSP_OFF_CONFIG      12'h004
`define RSP_OFF_IRQ_STATUS  12'h008
`define RSP_OFF_IRQ_MASK    12'h00c
`define RSP_OFF_TOP         12'h010

// Pointer register fields
`define RSP_PTR_LSB         0
`define RSP_PTR_MSB         4
`define RSP_UNDERFLOW_BIT   6
`define RSP_FULL_BIT        7

// Config, status and mask fields
`define RSP_CFG_OVF_BIT     0
`define RSP_IRQ_FULL_BIT    0
`define RSP_IRQ_UNF_BIT     1

// Reset values and fixed figures
`define RSP_PTR_RESET       5'h00
`define RSP_PTR_MAX         5'h1f
`define RSP_CFG_OVF_RESET   1'b1
`define RSP_IRQ_RESET       2'h0
`define RSP_PC_STEP         21'h000002
`define RSP_UNDERFLOW_PC    21'h000000

`endif

// *** shared/return_stack_pkg.sv ***
`default_nettype none
package return_stack_pkg;

  localparam int PTR_W = 5;
  localparam int PC_W  = 21;

  // Request from the instruction sequencer
  typedef struct packed {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] pc;
  } stack_req_type;

  // Answer to a pop, one cycle after it
  typedef struct packed {
    logic            valid;
    logic            underflow;
    logic [PC_W-1:0] pc;
  } stack_resp_type;

endpackage : return_stack_pkg
`default_nettype wire
